// *** core/gpc_pkg.sv ***
// Shared constants, masks, types and helpers for the port pin controller
package gpc_pkg;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int NPORT = 16;
    localparam int NPIN  = NPORT * 8;

    typedef logic [NPORT-1:0][7:0] gpc_bank_t;

    // ****************************************************************
    // Register groups and word indices (byte address = 4 * index)
    // ****************************************************************
    typedef enum logic [2:0] {
        G_LAT  = 3'b000,
        G_DIR  = 3'b001,
        G_PU   = 3'b010,
        G_PIM  = 3'b011,
        G_POM  = 3'b100,
        G_PMC  = 3'b101,
        G_INV  = 3'b110,
        G_NONE = 3'b111
    } gpc_grp_e;

    localparam logic [7:0] IDX_LAT_BASE = 8'h00;
    localparam logic [7:0] IDX_DIR_BASE = 8'h20;
    localparam logic [7:0] IDX_PU_BASE  = 8'h30;
    localparam logic [7:0] IDX_PIM_BASE = 8'h40;
    localparam logic [7:0] IDX_POM_BASE = 8'h50;
    localparam logic [7:0] IDX_PMC_BASE = 8'h60;
    localparam logic [7:0] IDX_INV_BASE = 8'h70;
    localparam int         IDX_LSB      = 2;
    localparam int         IDX_W        = 8;

    // Ports 9 and 11 do not exist
    localparam logic [NPORT-1:0] PORT_IMPL = 16'hF5FF;

    // ****************************************************************
    // Implemented-bit masks, ports 15 down to 0
    // ****************************************************************
    localparam gpc_bank_t MSK_DIR = {8'h1D, 8'h0F, 8'h00, 8'hE0,
        8'h00, 8'hFB, 8'h00, 8'h03, 8'hFF, 8'h03, 8'hFF, 8'h1F,
        8'hFF, 8'hFB, 8'hFE, 8'hFF};
    localparam gpc_bank_t MSK_LAT = {8'h1D, 8'h0F, 8'h01, 8'hE0,
        8'h00, 8'hFB, 8'h00, 8'h03, 8'hFF, 8'h03, 8'hFF, 8'h1F,
        8'hFF, 8'hFB, 8'hFE, 8'hFF};
    localparam gpc_bank_t FIX_IN  = {8'h00, 8'h00, 8'h80, 8'h1E,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00};
    localparam gpc_bank_t FIX_OUT = {8'h00, 8'h00, 8'h01, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00};
    localparam gpc_bank_t MSK_PU  = {8'h00, 8'h00, 8'h00, 8'hE0,
        8'h00, 8'h00, 8'h00, 8'h03, 8'hFF, 8'h00, 8'hFF, 8'h1F,
        8'hFF, 8'h00, 8'hFE, 8'hFF};
    localparam gpc_bank_t MSK_PIM = {8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h13,
        8'h60, 8'h00, 8'h12, 8'h03};
    localparam gpc_bank_t MSK_POM = {8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h1B,
        8'hE0, 8'h00, 8'h16, 8'h07};
    localparam gpc_bank_t MSK_PMC = {8'h1D, 8'h0F, 8'h00, 8'h00,
        8'h00, 8'hFB, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h18,
        8'h00, 8'hFB, 8'h00, 8'h00};
    localparam gpc_bank_t FIX_OD  = {8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00};
    localparam gpc_bank_t ANA_OUT = {8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h01, 8'h00, 8'h00};

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam gpc_bank_t RST_LAT  = '0;
    localparam gpc_bank_t RST_DIR  = {NPORT{8'hFF}};
    localparam gpc_bank_t RST_ZERO = '0;
    // Port 4 analog-capable bits start digital
    localparam gpc_bank_t RST_PMC = {8'h1D, 8'h0F, 8'h00, 8'h00,
        8'h00, 8'hFB, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'hFB, 8'h00, 8'h00};
    localparam gpc_bank_t RST_INV = {8'h00, 8'h00, 8'h00, 8'hE0,
        8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00,
        8'hFF, 8'h00, 8'hFE, 8'hFF};
    localparam gpc_bank_t MSK_INV = RST_INV;

    // ****************************************************************
    // Bus slave states and constants
    // ****************************************************************
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_WAIT = 2'b01
    } gpc_state_e;

    localparam logic       HRESP_OKAY = 1'b0;
    localparam logic [1:0] HTRANS_SEQ_BIT_SET = 2'b10;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [7:0] merge_bits(input logic [7:0] w,
                                              input logic [7:0] m,
                                              input logic [7:0] r);
        merge_bits = (w & m) | (r & ~m);
    endfunction

    function automatic gpc_grp_e decode_grp(input logic [IDX_W-1:0] idx);
        logic [3:0] hi;
        hi = idx[7:4];
        if (!PORT_IMPL[idx[3:0]]) begin
            decode_grp = G_NONE;
        end else if (hi == IDX_LAT_BASE[7:4]) begin
            decode_grp = G_LAT;
        end else if (hi == IDX_DIR_BASE[7:4]) begin
            decode_grp = G_DIR;
        end else if (hi == IDX_PU_BASE[7:4]) begin
            decode_grp = G_PU;
        end else if (hi == IDX_PIM_BASE[7:4]) begin
            decode_grp = G_PIM;
        end else if (hi == IDX_POM_BASE[7:4]) begin
            decode_grp = G_POM;
        end else if (hi == IDX_PMC_BASE[7:4]) begin
            decode_grp = G_PMC;
        end else if (hi == IDX_INV_BASE[7:4]) begin
            decode_grp = G_INV;
        end else begin
            decode_grp = G_NONE;
        end
    endfunction

endpackage

// *** core/gpc_reg_if.sv ***
// Register access channel between bus slave and register bank
`timescale 1ns/1ps
interface gpc_reg_if;
    import gpc_pkg::*;
    logic       acc_en;
    logic       acc_wr;
    gpc_grp_e   grp;
    logic [3:0] port;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport bus  (output acc_en, acc_wr, grp, port, wdata, input rdata);
    modport regs (input acc_en, acc_wr, grp, port, wdata, output rdata);
endinterface

// *** core/gpc_sync.sv ***
// Two-flop synchroniser for pin levels
`timescale 1ns/1ps
module gpc_sync
    import gpc_pkg::*;
#(
    parameter int W = NPIN
) (
    input  wire logic         clk_sys,
    input  wire logic         nrst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } gpc_sync_s;

    gpc_sync_s st_r;
    gpc_sync_s st_nxt;

    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
        if (!nrst) begin
            st_nxt = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        st_r <= st_nxt;
    end

    assign q = st_r.s2;
endmodule

// *** core/gpc_ahb_slave.sv ***
// AHB-Lite slave front end with one wait state per transfer
`timescale 1ns/1ps
module gpc_ahb_slave
    import gpc_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    gpc_reg_if.bus           rif
);
    typedef struct packed {
        gpc_state_e  state;
        logic        wr;
        gpc_grp_e    grp;
        logic [3:0]  port;
        logic        rdy;
        logic [31:0] rdata;
    } gpc_ahb_s;

    gpc_ahb_s st_r;
    gpc_ahb_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        case (st_r.state)
            S_IDLE: begin
                if (hsel && hready && (htrans & HTRANS_SEQ_BIT_SET) != '0)
                begin
                    st_nxt.state = S_WAIT;
                    st_nxt.wr    = hwrite;
                    st_nxt.grp   = decode_grp(haddr[IDX_LSB +: IDX_W]);
                    st_nxt.port  = haddr[IDX_LSB +: 4];
                    st_nxt.rdy   = 1'b0;
                end
            end
            S_WAIT: begin
                // Unmapped reads return zero, unmapped writes are dropped
                st_nxt.state = S_IDLE;
                st_nxt.rdy   = 1'b1;
                st_nxt.rdata = '0;
                if (!st_r.wr && st_r.grp != G_NONE) begin
                    st_nxt.rdata[7:0] = rif.rdata;
                end
            end
            default: begin
                st_nxt.state = S_IDLE;
                st_nxt.rdy   = 1'b1;
            end
        endcase
        if (!nrst) begin
            st_nxt       = '0;
            st_nxt.state = S_IDLE;
            st_nxt.grp   = G_NONE;
            st_nxt.rdy   = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        st_r <= st_nxt;
    end

    assign rif.acc_en = (st_r.state == S_WAIT) && (st_r.grp != G_NONE);
    assign rif.acc_wr = st_r.wr;
    assign rif.grp    = st_r.grp;
    assign rif.port   = st_r.port;
    assign rif.wdata  = hwdata[7:0];
    assign hreadyout  = st_r.rdy;
    assign hrdata     = st_r.rdata;
    assign hresp      = HRESP_OKAY;
endmodule

// *** core/gpc_top.sv ***
// Port pin controller: register bank, pin drive and read-back
`timescale 1ns/1ps
module gpc_top
    import gpc_pkg::*;
(
    input  wire logic            clk_sys,
    input  wire logic            nrst,
    input  wire logic            hsel,
    input  wire logic [31:0]     haddr,
    input  wire logic [1:0]      htrans,
    input  wire logic            hwrite,
    input  wire logic [2:0]      hsize,
    input  wire logic [31:0]     hwdata,
    input  wire logic            hready,
    output logic                 hreadyout,
    output logic [31:0]          hrdata,
    output logic                 hresp,
    input  wire logic [NPIN-1:0] pin_in,
    output logic      [NPIN-1:0] pin_out,
    output logic      [NPIN-1:0] pin_oe,
    output logic      [NPIN-1:0] pull_en,
    output logic      [NPIN-1:0] ttl_sel,
    output logic      [NPIN-1:0] analog_sel,
    output logic      [NPIN-1:0] analog_out_sel,
    output logic      [NPIN-1:0] dig_in_en,
    output logic      [NPIN-1:0] lcd_out_en
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        gpc_bank_t       lat;
        gpc_bank_t       dir;
        gpc_bank_t       pu;
        gpc_bank_t       pim;
        gpc_bank_t       pom;
        gpc_bank_t       pmc;
        gpc_bank_t       inv;
        logic [NPIN-1:0] out;
        logic [NPIN-1:0] oe;
        logic [NPIN-1:0] pull;
        logic [NPIN-1:0] ttl;
        logic [NPIN-1:0] ana;
        logic [NPIN-1:0] ana_out;
        logic [NPIN-1:0] din;
        logic [NPIN-1:0] lcd;
    } gpc_top_s;

    gpc_top_s        st_r;
    gpc_top_s        st_nxt;
    logic [NPIN-1:0] pin_s;
    logic [7:0]      rd_byte;

    gpc_reg_if rif ();

    // ****************************************************************
    // Bus slave and pin synchroniser
    // ****************************************************************
    gpc_ahb_slave u_ahb (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hwdata    (hwdata),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hrdata    (hrdata),
        .hresp     (hresp),
        .rif       (rif.bus)
    );

    // Pins are asynchronous to clk_sys
    gpc_sync #(
        .W (NPIN)
    ) u_sync (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .d       (pin_in),
        .q       (pin_s)
    );

    // ****************************************************************
    // Register read-back
    // ****************************************************************
    always_comb begin
        logic [3:0] p;
        logic [7:0] fin;
        p       = rif.port;
        fin     = (st_r.dir[p] | FIX_IN[p]) & ~FIX_OUT[p];
        rd_byte = '0;
        case (rif.grp)
            G_LAT: begin
                // Analog or invalid pins set as inputs read 0 via the disabled input; as outputs they read the latch
                rd_byte = ((fin & pin_s[p*8 +: 8] & st_r.din[p*8 +: 8])
                          | (~fin & st_r.lat[p]))
                          & (MSK_LAT[p] | FIX_IN[p]);
            end
            G_DIR:   rd_byte = st_r.dir[p];
            G_PU:    rd_byte = st_r.pu[p];
            G_PIM:   rd_byte = st_r.pim[p];
            G_POM:   rd_byte = st_r.pom[p];
            G_PMC:   rd_byte = st_r.pmc[p];
            G_INV:   rd_byte = st_r.inv[p];
            default: rd_byte = '0;
        endcase
    end

    assign rif.rdata = rd_byte;

    // ****************************************************************
    // Register writes, reset and pin drive
    // ****************************************************************
    always_comb begin
        logic [3:0] wp;
        logic [7:0] wd;
        logic       fin;
        logic       dok;
        logic       impl;
        logic       omode;
        logic       od;
        int         i;
        wp     = rif.port;
        wd     = rif.wdata;
        fin    = 1'b0;
        dok    = 1'b0;
        impl   = 1'b0;
        omode  = 1'b0;
        od     = 1'b0;
        i      = 0;
        st_nxt = st_r;

        // Masked merge keeps absent bits at reset value
        if (rif.acc_en && rif.acc_wr) begin
            case (rif.grp)
                G_LAT: st_nxt.lat[wp] = merge_bits(wd, MSK_LAT[wp],
                                                   RST_LAT[wp]);
                G_DIR: st_nxt.dir[wp] = merge_bits(wd, MSK_DIR[wp],
                                                   RST_DIR[wp]);
                G_PU:  st_nxt.pu[wp]  = merge_bits(wd, MSK_PU[wp],
                                                   RST_ZERO[wp]);
                G_PIM: st_nxt.pim[wp] = merge_bits(wd, MSK_PIM[wp],
                                                   RST_ZERO[wp]);
                G_POM: st_nxt.pom[wp] = merge_bits(wd, MSK_POM[wp],
                                                   RST_ZERO[wp]);
                G_PMC: st_nxt.pmc[wp] = merge_bits(wd, MSK_PMC[wp],
                                                   RST_PMC[wp]);
                G_INV: st_nxt.inv[wp] = merge_bits(wd, MSK_INV[wp],
                                                   RST_INV[wp]);
                default: st_nxt.lat[wp] = st_r.lat[wp];
            endcase
        end

        if (!nrst) begin
            st_nxt.lat = RST_LAT;
            st_nxt.dir = RST_DIR;
            st_nxt.pu  = RST_ZERO;
            st_nxt.pim = RST_ZERO;
            st_nxt.pom = RST_ZERO;
            st_nxt.pmc = RST_PMC;
            st_nxt.inv = RST_INV;
        end

        // Pin drive follows the next register values, so a write or
        // reset reaches the pins at the same edge it lands
        for (i = 0; i < NPIN; i++) begin
            impl = MSK_DIR[i/8][i%8] | FIX_IN[i/8][i%8]
                 | FIX_OUT[i/8][i%8];
            // Fixed pins ignore the direction bit
            fin  = (st_nxt.dir[i/8][i%8] | FIX_IN[i/8][i%8])
                 & ~FIX_OUT[i/8][i%8];
            dok  = impl & ~st_nxt.pmc[i/8][i%8]
                 & ~st_nxt.inv[i/8][i%8];
            omode = dok & ~fin;
            od   = st_nxt.pom[i/8][i%8] | FIX_OD[i/8][i%8];
            // Open-drain drives only the low level
            st_nxt.oe[i]   = omode & (~od | ~st_nxt.lat[i/8][i%8]);
            st_nxt.out[i]  = st_nxt.lat[i/8][i%8] & ~od;
            st_nxt.pull[i] = st_nxt.pu[i/8][i%8] & fin & dok;
            st_nxt.ttl[i]  = st_nxt.pim[i/8][i%8];
            st_nxt.ana[i]  = st_nxt.pmc[i/8][i%8];
            st_nxt.ana_out[i] = st_nxt.pmc[i/8][i%8]
                              & ANA_OUT[i/8][i%8];
            st_nxt.din[i]  = dok;
            st_nxt.lcd[i]  = impl & ~st_nxt.inv[i/8][i%8];
        end
    end

    always_ff @(posedge clk_sys) begin
        st_r <= st_nxt;
    end

    // ****************************************************************
    // Outputs, all from flops
    // ****************************************************************
    assign pin_out        = st_r.out;
    assign pin_oe         = st_r.oe;
    assign pull_en        = st_r.pull;
    assign ttl_sel        = st_r.ttl;
    assign analog_sel     = st_r.ana;
    assign analog_out_sel = st_r.ana_out;
    assign dig_in_en      = st_r.din;
    assign lcd_out_en     = st_r.lcd;

endmodule

// *** tb/gpc_checker.sv ***
// Concurrent checks on the port pin controller top ports
`timescale 1ns/1ps
module gpc_checker
    import gpc_pkg::*;
(
    input wire logic            clk_sys,
    input wire logic            nrst,
    input wire logic            hsel,
    input wire logic [31:0]     haddr,
    input wire logic [1:0]      htrans,
    input wire logic            hwrite,
    input wire logic [2:0]      hsize,
    input wire logic [31:0]     hwdata,
    input wire logic            hready,
    input wire logic            hreadyout,
    input wire logic [31:0]     hrdata,
    input wire logic            hresp,
    input wire logic [NPIN-1:0] pin_in,
    input wire logic [NPIN-1:0] pin_out,
    input wire logic [NPIN-1:0] pin_oe,
    input wire logic [NPIN-1:0] pull_en,
    input wire logic [NPIN-1:0] ttl_sel,
    input wire logic [NPIN-1:0] analog_sel,
    input wire logic [NPIN-1:0] analog_out_sel,
    input wire logic [NPIN-1:0] dig_in_en,
    input wire logic [NPIN-1:0] lcd_out_en
);
    // ****************************************************************
    // Properties
    // ****************************************************************
    // Ports 4 and 6 plus the fixed pins are live out of reset
    localparam gpc_bank_t DIG_RST = FIX_IN | FIX_OUT
        | 128'h0003_001F_0000_0000;
    logic acc;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    assign acc = hsel & hready & htrans[1] & hreadyout;

    rst_drive_a: assert property ($rose(nrst) |->
        pin_oe == FIX_OUT && pin_out == '0) else $error("reset drive");
    rst_analog_a: assert property ($rose(nrst) |->
        analog_sel == RST_PMC && analog_out_sel == ANA_OUT)
        else $error("reset analog");
    rst_input_a: assert property ($rose(nrst) |->
        dig_in_en == DIG_RST && (lcd_out_en & RST_INV) == '0)
        else $error("reset input");
    invalid_off_a: assert property (
        (~lcd_out_en & (pin_oe | dig_in_en)) == '0) else $error("invalid");
    pull_input_a: assert property (
        (pull_en & (pin_oe | ~MSK_PU)) == '0) else $error("pull");
    fixed_pins_a: assert property (
        (pin_oe & FIX_IN) == '0 && pin_oe[104]) else $error("fixed pin");
    od_fixed_a: assert property (
        pin_out[49:48] == 2'h0) else $error("open drain");
    sel_mask_a: assert property (
        (ttl_sel & ~MSK_PIM) == '0 && (analog_sel & ~MSK_PMC) == '0)
        else $error("select mask");
    bus_wait_a: assert property (
        acc |=> !hreadyout && !hresp ##1 hreadyout) else $error("wait");
    rdata_hold_a: assert property (
        $past(nrst) && hreadyout && $past(hreadyout) |->
        $stable(hrdata) && hrdata[31:8] == 24'h0) else $error("rdata");

    wr_seen_c: cover property (acc && hwrite);
    rd_seen_c: cover property (acc && !hwrite);
    drive_seen_c: cover property ((pin_oe & ~FIX_OUT) != '0);
endmodule

bind gpc_top gpc_checker gpc_checker_inst (.clk_sys(clk_sys), .nrst(nrst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pull_en(pull_en), .ttl_sel(ttl_sel), .analog_sel(analog_sel),
    .analog_out_sel(analog_out_sel), .dig_in_en(dig_in_en),
    .lcd_out_en(lcd_out_en));

// *** tb/gpc_pin_model.sv ***
// Behavioural model of the package pins and the board around them
`timescale 1ns/1ps
module gpc_pin_model
    import gpc_pkg::*;
(
    input  wire logic            clk_sys,
    input  wire logic [NPIN-1:0] pin_out,
    input  wire logic [NPIN-1:0] pin_oe,
    input  wire logic [NPIN-1:0] pull_en,
    input  wire logic [NPIN-1:0] ext_val,
    input  wire logic [NPIN-1:0] ext_en,
    output logic      [NPIN-1:0] pin_in
);
    logic [NPIN-1:0] flt_r;

    // Floating pins wander so a stale level never reads back
    initial flt_r = '0;
    always @(posedge clk_sys) flt_r <= ~flt_r;

    // Chip drive wins; pull-up only lifts released pins
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & (pull_en | flt_r));
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the port pin controller
`timescale 1ns/1ps
module testbench;
    import gpc_pkg::*;
    logic            clk_sys, hreadyout, hresp;
    logic            nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0]     haddr = '0, hwdata = '0, hrdata;
    logic [1:0]      htrans = 2'h0;
    logic [NPIN-1:0] pin_in, pin_out, pin_oe, pull_en, ttl_sel;
    logic [NPIN-1:0] an_sel, an_out, dig_in_en, lcd_out_en;
    gpc_bank_t       ext_val = '0, ext_en = '1;
    logic [31:0]     rng = 32'h27;
    logic [31:0]     q_exp[$];
    logic [7:0]      w;
    int              fails = 0, check_count = 0, cycles = 0;
    bit              rd_dp = 1'b0;

    gpc_top gpc_top_inst (.clk_sys(clk_sys), .nrst(nrst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pull_en(pull_en),
        .ttl_sel(ttl_sel), .analog_sel(an_sel), .analog_out_sel(an_out),
        .dig_in_en(dig_in_en), .lcd_out_en(lcd_out_en));
    gpc_pin_model gpc_pin_model_inst (.clk_sys(clk_sys), .pin_out(pin_out),
        .pin_oe(pin_oe), .pull_en(pull_en), .ext_val(ext_val),
        .ext_en(ext_en), .pin_in(pin_in));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic stop_test();
        $display("Checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [127:0] seen,
                         input logic [127:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [7:0] exp_rd(input int g, input int p,
                                          input logic [7:0] v);
        logic [7:0] m;
        m = (g == 2) ? MSK_DIR[p] : (g == 3) ? MSK_PU[p] :
            (g == 4) ? MSK_PIM[p] : (g == 5) ? MSK_POM[p] :
            (g == 6) ? MSK_PMC[p] : MSK_INV[p];
        if (!PORT_IMPL[p]) return 8'h00;
        return (g == 2) ? (v | ~m) : (v & m);
    endfunction

    function automatic logic [7:0] rst_v(input int g, input int p);
        return (g == 2) ? 8'hFF : (g == 6) ? RST_PMC[p] :
               (g == 7) ? RST_INV[p] : 8'h00;
    endfunction

    // Address phase held until hready, then data phase until hready
    task automatic xfer(input logic wr, input int idx, input logic [7:0] wd,
                        input logic [7:0] ex);
        rng = xs(rng);
        if (!wr) q_exp.push_back({24'h000000, ex});
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {22'h000000, idx[7:0], 2'h0};
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        htrans <= 2'h0;
        hwdata <= {rng[31:8], wd};
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
    endtask

    task automatic do_reset();
        nrst <= 1'b0;
        @(posedge clk_sys);
        #1;
        check("p13 reset", {pin_oe[104], pin_out[104]}, 2'h2);
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // Read results are taken at the edge that ends their data phase
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles > 3000) begin
            fails++;
            stop_test();
        end
        if (rd_dp && hreadyout === 1'b1) begin
            check("hrdata", hrdata, q_exp.pop_front());
            rd_dp = 1'b0;
        end
        if (hsel && htrans[1] && hreadyout && !hwrite) rd_dp = 1'b1;
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        do_reset();
        for (int g = 2; g < 8; g++) begin
            for (int p = 0; p < 16; p++) begin
                xfer(1'b0, g * 16 + p, 8'h00, exp_rd(g, p, rst_v(g, p)));
            end
        end
        xfer(1'b0, 8'h85, 8'h00, 8'h00);
        $display("Reset values done");
        for (int g = 2; g < 8; g++) begin
            for (int p = 0; p < 16; p++) begin
                w = rng[15:8];
                xfer(1'b1, g * 16 + p, w, 8'h00);
                xfer(1'b0, g * 16 + p, 8'h00, exp_rd(g, p, w));
            end
        end
        $display("Register masks done");
        xfer(1'b1, 8'h0D, 8'h01, 8'h00);
        check("p13 high", pin_out[104], 1'b1);
        do_reset();
        ext_val <= {4{rng}};
        ext_en <= ~128'hF000_0000;
        repeat (3) @(posedge clk_sys);
        xfer(1'b0, 8'h04, 8'h00, ext_val[4] & 8'h1F);
        xfer(1'b0, 8'h06, 8'h00, ext_val[6] & 8'h03);
        xfer(1'b0, 8'h0C, 8'h00, ext_val[12] & 8'h1E);
        xfer(1'b0, 8'h0D, 8'h00, {ext_val[13][7], 7'h00});
        xfer(1'b0, 8'h0E, 8'h00, 8'h00);
        xfer(1'b1, 8'h6E, 8'h00, 8'h00);
        check("p14 analog", an_sel[119:112], 8'h00);
        xfer(1'b0, 8'h0E, 8'h00, ext_val[14] & 8'h0F);
        xfer(1'b1, 8'h44, 8'hFF, 8'h00);
        check("p4 ttl", ttl_sel[39:32], 8'h13);
        $display("Input paths done");
        xfer(1'b1, 8'h73, 8'h00, 8'h00);
        xfer(1'b1, 8'h23, 8'hF0, 8'h00);
        xfer(1'b1, 8'h33, 8'hF0, 8'h00);
        xfer(1'b1, 8'h03, 8'hA5, 8'h00);
        check("p3 oe", pin_oe[31:24], 8'h0F);
        check("p3 out", pin_out[27:24], 4'h5);
        check("p3 pull", pull_en[31:24], 8'hF0);
        repeat (3) @(posedge clk_sys);
        xfer(1'b0, 8'h03, 8'h00, 8'hF5);
        xfer(1'b1, 8'h53, 8'hFF, 8'h00);
        xfer(1'b1, 8'h23, 8'h10, 8'h00);
        check("p3 od", {pin_oe[31:24], pin_out[31:24]}, 16'h4F05);
        xfer(1'b1, 8'h73, 8'hFF, 8'h00);
        check("p3 off", {pin_oe[31:24], dig_in_en[31:24]}, 16'h0);
        check("p3 lcd", lcd_out_en[31:24], 8'h00);
        $display("Port 3 done");
        xfer(1'b1, 8'h26, 8'h00, 8'h00);
        xfer(1'b0, 8'h06, 8'h00, 8'h00);
        check("p6 low", {pin_oe[49:48], pin_out[49:48]}, 4'hC);
        xfer(1'b1, 8'h06, 8'h01, 8'h00);
        check("p6 od", {pin_oe[49:48], pin_out[49:48]}, 4'h8);
        $display("Port 6 done");
        repeat (2) @(posedge clk_sys);
        stop_test();
    end
endmodule
